//--- hdl/euc_pkg.sv
package euc_pkg;

    // ------------------------------------------------------------
    // register address and layout
    // ------------------------------------------------------------
    localparam logic [31:0] CTRL_REG_ADDR = 32'h0000_007D;
    localparam int BIT_PERF_CLEAR = 31;
    localparam int BIT_PERF_SHIFT_ACCUM = 22;
    localparam int BIT_PERF_EXEC_SEL_HI = 21;
    localparam int BIT_PERF_EXEC_SEL_LO = 19;
    localparam int BIT_PERF_SOURCE_HI = 18;
    localparam int BIT_PERF_SOURCE_LO = 17;
    localparam int BIT_PERF_ENABLE = 16;
    localparam int BIT_FLOAT_TEST = 13;
    localparam int BIT_TIMEOUT_MSB = 6;
    localparam int BIT_TIMEOUT_SHORT = 5;
    localparam int BIT_TIMEOUT_SEEN = 4;
    localparam int BIT_FLOAT_STAGE4 = 3;
    localparam int BIT_TIMEOUT_DISABLE = 2;
    localparam int BIT_FLOAT_ENABLE = 1;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic RST_BIT = 1'b0;
    localparam logic [2:0] RST_EXEC_SEL = 3'h0;
    localparam logic [1:0] RST_SOURCE = 2'h0;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [27:0] RST_COUNT = 28'h000_0000;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam longint unsigned CLK_PERIOD_NS = 64'h0000_0000_0000_0014;
    localparam longint unsigned TO_SHORT_NS = 64'h0000_0000_0000_C350;
    localparam longint unsigned TO_LONG_NS = 64'h0000_0000_B2D0_5E00;
    // "roughly" periods, so rounding down is acceptable
    localparam logic [27:0] TO_SHORT_CYCLES = 28'(TO_SHORT_NS / CLK_PERIOD_NS);
    localparam logic [27:0] TO_LONG_CYCLES_DEF = 28'(TO_LONG_NS / CLK_PERIOD_NS);

endpackage : euc_pkg

//--- hdl/euc_stall_timer.sv
`timescale 1ns/100ps

module euc_stall_timer
    import euc_pkg::*;
#(
    parameter logic [27:0] LONG_CYCLES = TO_LONG_CYCLES_DEF
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // control
    input wire logic enable_i,
    input wire logic short_sel_i,
    input wire logic stall_i,
    // status
    output logic base_msb_o,
    output logic timeout_o
);

    // ------------------------------------------------------------
    // base counter
    // ------------------------------------------------------------
    logic [27:0] cnt_q, cnt_d;
    logic stall_q, stall_d;
    logic msb_q, msb_d;
    logic to_q, to_d;
    logic [27:0] period;
    logic restart;
    logic at_end;

    always_comb begin
        period = short_sel_i ? TO_SHORT_CYCLES : LONG_CYCLES;
        stall_d = stall_i;
        // both edges of the stall restart the count, so a stall is timed from its start
        restart = stall_i != stall_q;
        // >= so that a shorter period chosen mid-count cannot be skipped over
        at_end = cnt_q >= (period - 28'h000_0001);
        if (!enable_i) begin
            cnt_d = RST_COUNT;
        end else if (restart || at_end) begin
            cnt_d = RST_COUNT;
        end else begin
            cnt_d = cnt_q + 28'h000_0001;
        end
        to_d = enable_i && stall_i && !restart && at_end;
        msb_d = enable_i && (cnt_d >= (period >> 1));
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q <= RST_COUNT;
            stall_q <= RST_BIT;
            msb_q <= RST_BIT;
            to_q <= RST_BIT;
        end else begin
            cnt_q <= cnt_d;
            stall_q <= stall_d;
            msb_q <= msb_d;
            to_q <= to_d;
        end
    end

    assign base_msb_o = msb_q;
    assign timeout_o = to_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic [27:0] run_q;

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            run_q <= RST_COUNT;
        end else if (stall_i && enable_i && short_sel_i) begin
            run_q <= run_q + 28'h000_0001;
        end else begin
            run_q <= RST_COUNT;
        end
    end

    property p_short_fire;
        @(posedge sys_clk_i) disable iff (rst_i)
        (run_q == TO_SHORT_CYCLES) && stall_i && enable_i && short_sel_i |=> timeout_o;
    endproperty
    a_short_fire: assert property (p_short_fire) else $error("short timeout missed");

    property p_fire_needs_stall;
        @(posedge sys_clk_i) disable iff (rst_i)
        timeout_o |-> $past(stall_i) && $past(stall_q);
    endproperty
    a_fire_needs_stall: assert property (p_fire_needs_stall) else $error("timeout without stall");

    property p_msb_idle;
        @(posedge sys_clk_i) disable iff (rst_i)
        !enable_i |=> !base_msb_o;
    endproperty
    a_msb_idle: assert property (p_msb_idle) else $error("base msb set while disabled");

endmodule : euc_stall_timer

//--- hdl/euc_ctrl_reg.sv
`timescale 1ns/100ps
//
// Contract
// - control register lives at processor register address 007D, read and write
// - writing one to bit 31 clears perf counters; reads as zero
// - bit 22 enables the perf shift-register accumulator test feature
// - bits 21:19 pick the counted execution-unit event
// - bits 18:17 pick the event source unit
// - bit 16 is the performance monitor enable
// - bit 13 puts the float unit in pass-through test mode
// - bit 6 reads the timeout base counter top bit
// - bit 5 picks about 50 us instead of about 3 s timeout
// - bit 4 sets on stall timeout, cleared by writing one
// - bit 3 enables float unit stage four bypass
// - bit 2 set disables stage three stall timeouts entirely
// - bit 1 enables the float unit

module euc_ctrl_reg
    import euc_pkg::*;
#(
    parameter logic [27:0] TIMEOUT_LONG_CYCLES = TO_LONG_CYCLES_DEF
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // processor register access
    input wire logic [31:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [31:0] reg_wdata_i,
    output logic [31:0] reg_rdata_o,
    output logic reg_ack_o,
    // pipeline status
    input wire logic stage_three_stall_i,
    // performance monitor controls
    output logic perf_counters_clear_o,
    output logic perf_shift_accum_enable_o,
    output logic [2:0] perf_exec_event_select_o,
    output logic [1:0] perf_source_select_o,
    output logic perf_monitor_enable_o,
    // float unit controls
    output logic float_unit_test_enable_o,
    output logic float_stage4_skip_enable_o,
    output logic float_unit_enable_o,
    // timeout status
    output logic timeout_seen_flag_o
);

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    function automatic logic ctrl_hit(input logic [31:0] addr);
        ctrl_hit = addr == CTRL_REG_ADDR;
    endfunction : ctrl_hit

    // ------------------------------------------------------------
    // register fields
    // ------------------------------------------------------------
    logic clear_q, clear_d;
    logic accum_q, accum_d;
    logic [2:0] exec_sel_q, exec_sel_d;
    logic [1:0] source_q, source_d;
    logic perf_en_q, perf_en_d;
    logic ftest_q, ftest_d;
    logic short_q, short_d;
    logic seen_q, seen_d;
    logic fskip_q, fskip_d;
    logic to_dis_q, to_dis_d;
    logic fen_q, fen_d;
    logic [31:0] rdata_q, rdata_d;
    logic ack_q, ack_d;
    logic wr_hit;
    logic base_msb;
    logic timeout_pulse;

    always_comb begin
        wr_hit = reg_wr_i && ctrl_hit(reg_addr_i);
        accum_d = accum_q;
        exec_sel_d = exec_sel_q;
        source_d = source_q;
        perf_en_d = perf_en_q;
        ftest_d = ftest_q;
        short_d = short_q;
        fskip_d = fskip_q;
        to_dis_d = to_dis_q;
        fen_d = fen_q;
        if (wr_hit) begin
            accum_d = reg_wdata_i[BIT_PERF_SHIFT_ACCUM];
            exec_sel_d = reg_wdata_i[BIT_PERF_EXEC_SEL_HI:BIT_PERF_EXEC_SEL_LO];
            source_d = reg_wdata_i[BIT_PERF_SOURCE_HI:BIT_PERF_SOURCE_LO];
            perf_en_d = reg_wdata_i[BIT_PERF_ENABLE];
            ftest_d = reg_wdata_i[BIT_FLOAT_TEST];
            short_d = reg_wdata_i[BIT_TIMEOUT_SHORT];
            fskip_d = reg_wdata_i[BIT_FLOAT_STAGE4];
            // software is meant to keep this zero; a one is still honoured
            to_dis_d = reg_wdata_i[BIT_TIMEOUT_DISABLE];
            fen_d = reg_wdata_i[BIT_FLOAT_ENABLE];
        end
        // one-cycle pulse, never stored in the readable word
        clear_d = wr_hit && reg_wdata_i[BIT_PERF_CLEAR];
        // a new timeout wins over a write-one clear in the same cycle
        seen_d = timeout_pulse || (seen_q && !(wr_hit && reg_wdata_i[BIT_TIMEOUT_SEEN]));
        ack_d = reg_wr_i || reg_rd_i;
        rdata_d = RST_WORD;
        if (reg_rd_i && ctrl_hit(reg_addr_i)) begin
            rdata_d[BIT_PERF_SHIFT_ACCUM] = accum_q;
            rdata_d[BIT_PERF_EXEC_SEL_HI:BIT_PERF_EXEC_SEL_LO] = exec_sel_q;
            rdata_d[BIT_PERF_SOURCE_HI:BIT_PERF_SOURCE_LO] = source_q;
            rdata_d[BIT_PERF_ENABLE] = perf_en_q;
            rdata_d[BIT_FLOAT_TEST] = ftest_q;
            rdata_d[BIT_TIMEOUT_MSB] = base_msb;
            rdata_d[BIT_TIMEOUT_SHORT] = short_q;
            rdata_d[BIT_TIMEOUT_SEEN] = seen_q;
            rdata_d[BIT_FLOAT_STAGE4] = fskip_q;
            rdata_d[BIT_TIMEOUT_DISABLE] = to_dis_q;
            rdata_d[BIT_FLOAT_ENABLE] = fen_q;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            clear_q <= RST_BIT;
            accum_q <= RST_BIT;
            exec_sel_q <= RST_EXEC_SEL;
            source_q <= RST_SOURCE;
            perf_en_q <= RST_BIT;
            ftest_q <= RST_BIT;
            short_q <= RST_BIT;
            seen_q <= RST_BIT;
            fskip_q <= RST_BIT;
            to_dis_q <= RST_BIT;
            fen_q <= RST_BIT;
            rdata_q <= RST_WORD;
            ack_q <= RST_BIT;
        end else begin
            clear_q <= clear_d;
            accum_q <= accum_d;
            exec_sel_q <= exec_sel_d;
            source_q <= source_d;
            perf_en_q <= perf_en_d;
            ftest_q <= ftest_d;
            short_q <= short_d;
            seen_q <= seen_d;
            fskip_q <= fskip_d;
            to_dis_q <= to_dis_d;
            fen_q <= fen_d;
            rdata_q <= rdata_d;
            ack_q <= ack_d;
        end
    end

    // ------------------------------------------------------------
    // stall timeout
    // ------------------------------------------------------------
    euc_stall_timer #(
        .LONG_CYCLES(TIMEOUT_LONG_CYCLES)
    ) u_timer (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .enable_i(!to_dis_q),
        .short_sel_i(short_q),
        .stall_i(stage_three_stall_i),
        .base_msb_o(base_msb),
        .timeout_o(timeout_pulse)
    );

    assign reg_rdata_o = rdata_q;
    assign reg_ack_o = ack_q;
    assign perf_counters_clear_o = clear_q;
    assign perf_shift_accum_enable_o = accum_q;
    assign perf_exec_event_select_o = exec_sel_q;
    assign perf_source_select_o = source_q;
    assign perf_monitor_enable_o = perf_en_q;
    assign float_unit_test_enable_o = ftest_q;
    assign float_stage4_skip_enable_o = fskip_q;
    assign float_unit_enable_o = fen_q;
    assign timeout_seen_flag_o = seen_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_ctrl_write;
        reg_wr_i && ctrl_hit(reg_addr_i);
    endsequence

    sequence s_ctrl_read;
        reg_rd_i && !reg_wr_i && ctrl_hit(reg_addr_i);
    endsequence

    property p_write_read_back;
        @(posedge sys_clk_i) disable iff (rst_i)
        s_ctrl_write ##1 s_ctrl_read |=>
            reg_rdata_o[BIT_FLOAT_ENABLE] == $past(reg_wdata_i[BIT_FLOAT_ENABLE], 2);
    endproperty
    a_write_read_back: assert property (p_write_read_back) else $error("bit 1 read back wrong");

    property p_clear_pulse;
        @(posedge sys_clk_i) disable iff (rst_i)
        s_ctrl_write and reg_wdata_i[BIT_PERF_CLEAR] |=> perf_counters_clear_o ##1
            (!perf_counters_clear_o || $past(wr_hit));
    endproperty
    a_clear_pulse: assert property (p_clear_pulse) else $error("clear pulse wrong");

    property p_clear_reads_zero;
        @(posedge sys_clk_i) disable iff (rst_i)
        reg_ack_o |-> !reg_rdata_o[BIT_PERF_CLEAR] && (reg_rdata_o[15:14] == 2'h0);
    endproperty
    a_clear_reads_zero: assert property (p_clear_reads_zero) else $error("undefined bit reads one");

    property p_fields_follow;
        @(posedge sys_clk_i) disable iff (rst_i)
        s_ctrl_write |=> perf_exec_event_select_o == $past(reg_wdata_i[21:19])
            && perf_source_select_o == $past(reg_wdata_i[18:17])
            && perf_shift_accum_enable_o == $past(reg_wdata_i[22])
            && perf_monitor_enable_o == $past(reg_wdata_i[16]);
    endproperty
    a_fields_follow: assert property (p_fields_follow) else $error("perf field not loaded");

    property p_float_fields;
        @(posedge sys_clk_i) disable iff (rst_i)
        s_ctrl_write |=> float_unit_test_enable_o == $past(reg_wdata_i[13])
            && float_stage4_skip_enable_o == $past(reg_wdata_i[3]);
    endproperty
    a_float_fields: assert property (p_float_fields) else $error("float field not loaded");

    property p_float_hold;
        @(posedge sys_clk_i) disable iff (rst_i)
        !wr_hit |=> $stable(float_unit_enable_o);
    endproperty
    a_float_hold: assert property (p_float_hold) else $error("float enable moved");

    property p_msb_read;
        @(posedge sys_clk_i) disable iff (rst_i)
        s_ctrl_read |=> reg_rdata_o[BIT_TIMEOUT_MSB] == $past(base_msb);
    endproperty
    a_msb_read: assert property (p_msb_read) else $error("base msb not visible");

    property p_seen_set;
        @(posedge sys_clk_i) disable iff (rst_i)
        timeout_pulse |=> timeout_seen_flag_o;
    endproperty
    a_seen_set: assert property (p_seen_set) else $error("timeout flag not set");

    property p_seen_sticky;
        @(posedge sys_clk_i) disable iff (rst_i)
        timeout_seen_flag_o && !(wr_hit && reg_wdata_i[BIT_TIMEOUT_SEEN]) |=> timeout_seen_flag_o;
    endproperty
    a_seen_sticky: assert property (p_seen_sticky) else $error("timeout flag lost");

    property p_disabled_quiet;
        @(posedge sys_clk_i) disable iff (rst_i)
        to_dis_q && $past(to_dis_q) |-> !timeout_pulse;
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet) else $error("timeout while disabled");

    property p_short_loaded;
        @(posedge sys_clk_i) disable iff (rst_i)
        s_ctrl_write |=> short_q == $past(reg_wdata_i[BIT_TIMEOUT_SHORT]);
    endproperty
    a_short_loaded: assert property (p_short_loaded) else $error("short select not loaded");

    property p_unmapped_zero;
        @(posedge sys_clk_i) disable iff (rst_i)
        reg_rd_i && !ctrl_hit(reg_addr_i) |=> reg_ack_o && reg_rdata_o == 32'h0000_0000;
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");

endmodule : euc_ctrl_reg

//--- testbench/tb.sv
`timescale 1ns/100ps

module tb;
    import euc_pkg::*;

    // ----------------------------------------
    // clock, reset and design ports
    // ----------------------------------------
    localparam logic [27:0] LONG_P = 28'h000_0BB8;
    localparam int SHORT_P = 2500;
    logic sys_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [31:0] reg_addr_i = 32'h0000_0000;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [31:0] reg_wdata_i = 32'h0000_0000;
    logic stage_three_stall_i = 1'b0;
    logic [31:0] reg_rdata_o;
    // bit 2 stays zero in every configuration word
    logic [31:0] word_list [8] = '{32'h0040_0000, 32'h0001_0000, 32'h0000_2000,
        32'h0000_0008, 32'h0000_0002, 32'h8000_0000, 32'h807F_202A, 32'h0000_0000};
    logic reg_ack_o, perf_counters_clear_o, perf_shift_accum_enable_o, perf_monitor_enable_o;
    logic [2:0] perf_exec_event_select_o;
    logic [1:0] perf_source_select_o;
    logic float_unit_test_enable_o, float_stage4_skip_enable_o, float_unit_enable_o;
    logic timeout_seen_flag_o;
    int n_mismatch = 0;
    int checks_done = 0;
    logic clr_seen;
    logic [31:0] rd_val;

    always #10 sys_clk_i = ~sys_clk_i;

    euc_ctrl_reg #(.TIMEOUT_LONG_CYCLES(LONG_P)) u_euc_ctrl_reg (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
        .reg_ack_o(reg_ack_o), .stage_three_stall_i(stage_three_stall_i),
        .perf_counters_clear_o(perf_counters_clear_o),
        .perf_shift_accum_enable_o(perf_shift_accum_enable_o),
        .perf_exec_event_select_o(perf_exec_event_select_o),
        .perf_source_select_o(perf_source_select_o),
        .perf_monitor_enable_o(perf_monitor_enable_o),
        .float_unit_test_enable_o(float_unit_test_enable_o),
        .float_stage4_skip_enable_o(float_stage4_skip_enable_o),
        .float_unit_enable_o(float_unit_enable_o), .timeout_seen_flag_o(timeout_seen_flag_o)
    );

    // ----------------------------------------
    // compare and report
    // ----------------------------------------
    task automatic complete_run();
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : complete_run

    task automatic check_word(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : check_word

    task automatic check_bit(input string name, input logic exp, input logic got);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %b seen %b", name, exp, got);
        end
    endtask : check_bit

    // ----------------------------------------
    // register access
    // ----------------------------------------
    // ack rises on the same edge that samples the request; the loop only guards a hang
    task automatic wait_ack();
        int i;
        for (i = 0; i < 4 && reg_ack_o !== 1'b1; i++) begin
            @(posedge sys_clk_i);
            #1;
        end
        if (reg_ack_o !== 1'b1) begin
            n_mismatch++;
            $display("Error ack expected 1 seen %b", reg_ack_o);
            complete_run();
        end
    endtask : wait_ack

    // lets one edge pass so a strobe is never lowered and raised in one time step
    task automatic idle_cycle();
        @(posedge sys_clk_i);
        #1;
    endtask : idle_cycle

    task automatic reg_write(input logic [31:0] addr, input logic [31:0] data);
        reg_addr_i = addr;
        reg_wdata_i = data;
        reg_wr_i = 1'b1;
        @(posedge sys_clk_i);
        #1;
        reg_wr_i = 1'b0;
        wait_ack();
        clr_seen = perf_counters_clear_o;
    endtask : reg_write

    task automatic reg_read(input logic [31:0] addr, output logic [31:0] data);
        reg_addr_i = addr;
        reg_rd_i = 1'b1;
        @(posedge sys_clk_i);
        #1;
        reg_rd_i = 1'b0;
        wait_ack();
        data = reg_rdata_o;
    endtask : reg_read

    // writes one word and checks every field output and the readback
    task automatic apply_word(input logic [31:0] w);
        reg_write(CTRL_REG_ADDR, w);
        check_bit("clear_pulse", w[31], clr_seen);
        reg_read(CTRL_REG_ADDR, rd_val);
        check_bit("clear_after", 1'b0, perf_counters_clear_o);
        check_word("readback", w & 32'h007F_202E, rd_val & 32'hFFFF_FFBF);
        check_bit("shift_accum", w[22], perf_shift_accum_enable_o);
        check_word("exec_sel", {29'h0, w[21:19]}, {29'h0, perf_exec_event_select_o});
        check_word("source_sel", {30'h0, w[18:17]}, {30'h0, perf_source_select_o});
        check_bit("perf_en", w[16], perf_monitor_enable_o);
        check_bit("float_test", w[13], float_unit_test_enable_o);
        check_bit("stage4_skip", w[3], float_stage4_skip_enable_o);
        check_bit("float_en", w[1], float_unit_enable_o);
    endtask : apply_word

    // holds the stall for n cycles and returns the cycle the flag first showed, or -1
    task automatic stall_for(input int n, output int hit);
        int i;
        hit = -1;
        stage_three_stall_i = 1'b1;
        for (i = 1; i <= n; i++) begin
            @(posedge sys_clk_i);
            #1;
            if (hit < 0 && timeout_seen_flag_o === 1'b1) begin
                hit = i;
            end
        end
        stage_three_stall_i = 1'b0;
        // the low edge restarts the base counter before any next stall
        idle_cycle();
    endtask : stall_for

    // samples bit 6 over more than one short period
    task automatic probe_msb(output logic seen0, output logic seen1);
        int i;
        seen0 = 1'b0;
        seen1 = 1'b0;
        for (i = 0; i < 1500; i++) begin
            reg_read(CTRL_REG_ADDR, rd_val);
            idle_cycle();
            if (rd_val[6] === 1'b0) seen0 = 1'b1;
            if (rd_val[6] === 1'b1) seen1 = 1'b1;
        end
    endtask : probe_msb

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        int k, hit;
        logic s0, s1;
        repeat (3) @(posedge sys_clk_i);
        #1;
        rst_i = 1'b0;
        reg_read(CTRL_REG_ADDR, rd_val);
        check_word("reset_word", 32'h0000_0000, rd_val);
        check_bit("reset_float_en", 1'b0, float_unit_enable_o);
        for (k = 0; k < 8; k++) apply_word(word_list[k]);
        for (k = 0; k < 8; k++) apply_word({10'h0, k[2:0], k[1:0], 17'h0});
        // unmapped place: write ignored, reads zero
        apply_word(32'h0000_0002);
        reg_write(32'h0000_007C, 32'hFFFF_FFFB);
        reg_read(32'h0000_007C, rd_val);
        check_word("unmapped_read", 32'h0000_0000, rd_val);
        idle_cycle();
        reg_read(CTRL_REG_ADDR, rd_val);
        check_word("after_unmapped", 32'h0000_0002, rd_val & 32'hFFFF_FFBF);
        // short period: base msb toggles, stall interrupted never fires
        reg_write(CTRL_REG_ADDR, 32'h0000_0020);
        probe_msb(s0, s1);
        check_bit("msb_low_seen", 1'b1, s0);
        check_bit("msb_high_seen", 1'b1, s1);
        stall_for(2000, hit);
        stall_for(2000, hit);
        check_bit("restart_no_flag", 1'b0, timeout_seen_flag_o);
        stall_for(2600, hit);
        check_bit("short_window", 1'b1, hit >= SHORT_P - 5 && hit <= SHORT_P + 5);
        reg_read(CTRL_REG_ADDR, rd_val);
        check_bit("seen_bit", 1'b1, rd_val[4]);
        reg_write(CTRL_REG_ADDR, 32'h0000_0020);
        check_bit("zero_keeps", 1'b1, timeout_seen_flag_o);
        idle_cycle();
        reg_write(CTRL_REG_ADDR, 32'h0000_0030);
        reg_read(CTRL_REG_ADDR, rd_val);
        check_bit("one_clears", 1'b0, rd_val[4]);
        // long period taken from the parameter
        reg_write(CTRL_REG_ADDR, 32'h0000_0000);
        stall_for(int'(LONG_P) + 20, hit);
        check_bit("long_window", 1'b1, hit >= int'(LONG_P) - 5 && hit <= int'(LONG_P) + 5);
        reg_write(CTRL_REG_ADDR, 32'h0000_0010);
        idle_cycle();
        // reserved bit set: no timeout, base counter held
        reg_write(CTRL_REG_ADDR, 32'h0000_0024);
        idle_cycle();
        probe_msb(s0, s1);
        check_bit("held_msb", 1'b0, s1);
        stall_for(3000, hit);
        check_bit("disabled_no_flag", 1'b0, timeout_seen_flag_o);
        complete_run();
    end

endmodule : tb
